/* File: crie_pkg.sv */
// Shared constants and types for the core register and interrupt entry block
package crie_pkg;

    // ****************************************************************
    // Vector addresses (high byte at the lower address)
    // ****************************************************************
    localparam logic [15:0] RESET_VECTOR = 16'h1ffe;
    localparam logic [15:0] EXT_VECTOR = 16'h1ffa;
    localparam logic [15:0] CORE_TIMER_VECTOR = 16'h1ff8;
    localparam logic [15:0] SUPPLY_VECTOR = 16'h1ff6;
    localparam logic [15:0] TIMER_VECTOR = 16'h1ff4;
    localparam logic [15:0] KEYPAD_VECTOR = 16'h1ff2;

    // ****************************************************************
    // Stack, program counter and condition code layout
    // ****************************************************************
    localparam logic [9:0] STACK_FIXED_BITS = 10'h003;
    localparam logic [5:0] STACK_TOP = 6'h3f;
    localparam int STACK_DEPTH = 64;
    localparam int PC_BITS = 14;
    localparam int CCR_HALF_POS = 4;
    localparam int CCR_MASK_POS = 3;
    localparam logic [7:0] CCR_FIXED = 8'he0;

    // ****************************************************************
    // Timer flag and enable fields
    // ****************************************************************
    localparam int TIMER_FIELD_LSB = 5;
    localparam int TIMER_FIELD_MSB = 7;

    // ****************************************************************
    // Supply monitor options byte
    // ****************************************************************
    localparam int OPT_FLAG_POS = 7;
    localparam int OPT_LEVEL_POS = 6;
    localparam int OPT_ACK_POS = 5;
    localparam int OPT_ENABLE_POS = 4;

    // Commands from the instruction sequencer
    typedef enum logic [3:0] {
        CMD_NONE, CMD_LOAD_A, CMD_LOAD_X, CMD_ADD, CMD_ADC, CMD_PUSH,
        CMD_PULL, CMD_RSP, CMD_FETCH, CMD_JUMP, CMD_CALL, CMD_CLI,
        CMD_SEI, CMD_STOP, CMD_WAIT
    } crie_cmd_type;

    // Sequencer states
    typedef enum logic [3:0] {
        S_IDLE, S_PUSH_PCL, S_PUSH_PCH, S_PUSH_X, S_PUSH_A, S_PUSH_CCR,
        S_VEC_HI, S_VEC_LO, S_VEC_CAP, S_VEC_END
    } crie_state_type;

endpackage : crie_pkg

/* File: crie_stack_mem.sv */
// Stack storage: 64 bytes, synchronous write, registered read data
`timescale 1ns/100ps
module crie_stack_mem
    import crie_pkg::*;
(
    input wire logic clock,
    input wire logic clock_en,
    input wire logic we,
    input wire logic [5:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic re,
    input wire logic [5:0] raddr,
    output logic [7:0] rdata
);

    logic [7:0] mem [STACK_DEPTH];

    // Write port; no reset, stack contents are not defined after reset
    always_ff @(posedge clock) begin
        if (clock_en && we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read port, data held until the next read
    always_ff @(posedge clock) begin
        if (clock_en && re) begin
            rdata <= mem[raddr];
        end
    end

endmodule : crie_stack_mem

/* File: crie_core.sv */
// Core programming model registers and interrupt entry sequencer
`timescale 1ns/100ps
// Behaviour
// - 8-bit accumulator, untouched by reset
// - 8-bit index register, untouched by reset
// - Stack pointer preset to top on reset/RSP
// - Push decrements, pull increments stack pointer
// - Upper ten stack bits fixed, 00C0-00FF
// - Stack wraps silently past 64 bytes
// - Call pushes two bytes, interrupt five
// - 16-bit PC, top two bits ignored
// - PC increments per fetch, loads on jumps
// - Half carry from bit 3 on add
// - Reset fetches start address from vector
// - Reset sets the interrupt mask
// - Enabled timer flags request shared vector
// - Timer flags/enables in top three bits
// - Input port C pins give keypad interrupt
// - Stop halts oscillator and all processing
// - Wait suspends core, timers keep running
// - Enabled interrupts end wait mode
// - Ack bit write-only, reads zero, clears
// - Supply pin edges interrupt, skip power-on rise
// - Disabled supply monitor raises no interrupt
// - Supply flag cleared by ack and reset
module crie_core
    import crie_pkg::*;
(
    input wire logic clock,
    input wire logic clock_en,
    input wire logic nrst,
    input wire logic power_on,
    input wire crie_cmd_type cmd,
    input wire logic [7:0] cmd_data,
    input wire logic [15:0] cmd_addr,
    input wire logic carry_in,
    output logic cmd_ready,
    output logic [7:0] accumulator,
    output logic [7:0] index_reg,
    output logic [15:0] stack_pointer,
    output logic [15:0] program_counter,
    output logic half_carry,
    output logic carry_out,
    output logic int_mask,
    output logic [7:0] pull_data,
    output logic [15:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] timer_status_reg,
    input wire logic [7:0] timer_control_reg,
    input wire logic [7:0] portc_in,
    input wire logic [7:0] portc_direction,
    input wire logic keypad_irq_enable,
    input wire logic ext_irq,
    input wire logic core_timer_irq,
    input wire logic supply_monitor_pin,
    input wire logic supply_irq_enable,
    input wire logic supply_irq_ack,
    output logic supply_irq_flag,
    output logic [7:0] supply_options,
    output logic osc_run,
    output logic wait_mode,
    output logic busy
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    function automatic logic nibble_carry(input logic [3:0] a,
                                          input logic [3:0] b,
                                          input logic c);
        logic [4:0] s;
        s = {1'b0, a} + {1'b0, b} + {4'h0, c};
        return s[4];
    endfunction : nibble_carry

    // ****************************************************************
    // State
    // ****************************************************************
    crie_state_type state;
    logic [5:0] sp;
    logic [13:0] pc;
    logic [15:0] vector;
    logic [7:0] vec_hi;
    logic [7:0] stack_wdata;
    logic [8:0] add_sum;
    logic stopped, in_call, pin_prev, skip_rise, accept, take_irq;
    logic timer_req, keypad_req, any_req, stop_wake, pin_rise, pin_fall;
    logic stack_we, pull_go, add_c;

    // Interrupt sources; timer, keypad and supply gated by their enables, ext and core timer ungated
    assign timer_req = |(timer_status_reg[TIMER_FIELD_MSB:TIMER_FIELD_LSB]
        & timer_control_reg[TIMER_FIELD_MSB:TIMER_FIELD_LSB]);
    // Wired-OR: any input-configured pin pulled low requests
    assign keypad_req = keypad_irq_enable
        & |(~portc_in & ~portc_direction);
    assign any_req = ext_irq | core_timer_irq | supply_irq_flag
        | timer_req | keypad_req;
    // Only pin-driven sources can restart a stopped oscillator
    assign stop_wake = ext_irq | keypad_req | supply_irq_flag;

    // Entry wins over a command presented in the same cycle
    assign take_irq = state == S_IDLE && !stopped && !wait_mode
        && !int_mask && any_req;
    assign cmd_ready = state == S_IDLE && !stopped && !wait_mode
        && !take_irq;
    assign accept = cmd_ready && cmd != CMD_NONE;
    assign busy = state != S_IDLE;
    assign pull_go = accept && cmd == CMD_PULL;
    assign add_c = cmd == CMD_ADC ? carry_in : 1'b0;
    assign add_sum = {1'b0, accumulator} + {1'b0, cmd_data}
        + {8'h00, add_c};

    // Upper bits are constants, only six bits are stored
    assign stack_pointer = {STACK_FIXED_BITS, sp};
    assign program_counter = {2'b00, pc};
    assign osc_run = !stopped;

    // ****************************************************************
    // Stack write data selection
    // ****************************************************************
    // Return address pushed low byte first, then high byte
    always_comb begin
        stack_we = 1'b1;
        case (state)
            S_PUSH_PCL: stack_wdata = pc[7:0];
            S_PUSH_PCH: stack_wdata = {2'b00, pc[13:8]};
            S_PUSH_X: stack_wdata = index_reg;
            S_PUSH_A: stack_wdata = accumulator;
            S_PUSH_CCR: stack_wdata = CCR_FIXED
                | ({7'h00, half_carry} << CCR_HALF_POS)
                | ({7'h00, int_mask} << CCR_MASK_POS);
            default: begin
                stack_we = accept && cmd == CMD_PUSH;
                stack_wdata = cmd_data;
            end
        endcase
    end

    crie_stack_mem u_stack (
        .clock(clock),
        .clock_en(clock_en),
        .we(stack_we),
        .waddr(sp),
        .wdata(stack_wdata),
        .re(pull_go),
        .raddr(sp + 6'h01),
        .rdata(pull_data)
    );

    // ****************************************************************
    // Accumulator, index register and flags
    // ****************************************************************
    // Neither register is cleared by reset, only loaded by commands
    always_ff @(posedge clock) begin
        if (clock_en && accept) begin
            case (cmd)
                CMD_LOAD_A: accumulator <= cmd_data;
                CMD_ADD, CMD_ADC: accumulator <= add_sum[7:0];
                CMD_LOAD_X: index_reg <= cmd_data;
                default: ;
            endcase
        end
    end

    // Half carry tracks the low nibble carry of each add
    always_ff @(posedge clock) begin
        if (!nrst) begin
            half_carry <= 1'b0;
            carry_out <= 1'b0;
        end else if (clock_en && accept
                     && (cmd == CMD_ADD || cmd == CMD_ADC)) begin
            half_carry <= nibble_carry(accumulator[3:0],
                                       cmd_data[3:0], add_c);
            carry_out <= add_sum[8];
        end
    end

    // ****************************************************************
    // Stack pointer
    // ****************************************************************
    // Six-bit arithmetic wraps from the bottom back to the top
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sp <= STACK_TOP;
        end else if (clock_en) begin
            if (accept && cmd == CMD_RSP) begin
                sp <= STACK_TOP;
            end else if (stack_we) begin
                sp <= sp - 6'h01;
            end else if (pull_go) begin
                sp <= sp + 6'h01;
            end
        end
    end

    // ****************************************************************
    // Sequencer: reset vector, call and interrupt entry
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state <= S_VEC_HI;
            vector <= RESET_VECTOR;
            in_call <= 1'b0;
        end else if (clock_en) begin
            case (state)
                S_IDLE: begin
                    if (take_irq) begin
                        state <= S_PUSH_PCL;
                        in_call <= 1'b0;
                        if (ext_irq) begin
                            vector <= EXT_VECTOR;
                        end else if (supply_irq_flag) begin
                            vector <= SUPPLY_VECTOR;
                        end else if (timer_req) begin
                            vector <= TIMER_VECTOR;
                        end else if (keypad_req) begin
                            vector <= KEYPAD_VECTOR;
                        end else begin
                            vector <= CORE_TIMER_VECTOR;
                        end
                    end else if (accept && cmd == CMD_CALL) begin
                        state <= S_PUSH_PCL;
                        in_call <= 1'b1;
                    end
                end
                S_PUSH_PCL: state <= S_PUSH_PCH;
                S_PUSH_PCH: state <= in_call ? S_IDLE : S_PUSH_X;
                S_PUSH_X: state <= S_PUSH_A;
                S_PUSH_A: state <= S_PUSH_CCR;
                S_PUSH_CCR: state <= S_VEC_HI;
                S_VEC_HI: state <= S_VEC_LO;
                S_VEC_LO: state <= S_VEC_CAP;
                S_VEC_CAP: state <= S_VEC_END;
                S_VEC_END: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // Vector reads: one-cycle read latency, high byte first
    always_ff @(posedge clock) begin
        if (!nrst) begin
            mem_rd <= 1'b0;
            mem_addr <= 16'h0000;
            vec_hi <= 8'h00;
        end else if (clock_en) begin
            mem_rd <= state == S_VEC_HI || state == S_VEC_LO;
            if (state == S_VEC_HI) begin
                mem_addr <= vector;
            end else if (state == S_VEC_LO) begin
                mem_addr <= vector + 16'h0001;
            end
            if (state == S_VEC_CAP) begin
                vec_hi <= mem_rdata;
            end
        end
    end

    // ****************************************************************
    // Program counter
    // ****************************************************************
    // Top two address bits are dropped on every load
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pc <= 14'h0000;
        end else if (clock_en) begin
            if (state == S_VEC_END) begin
                pc <= {vec_hi[PC_BITS-9:0], mem_rdata};
            end else if (state == S_PUSH_PCH && in_call) begin
                pc <= cmd_addr[PC_BITS-1:0];
            end else if (accept && cmd == CMD_JUMP) begin
                pc <= cmd_addr[PC_BITS-1:0];
            end else if (accept && cmd == CMD_FETCH) begin
                pc <= pc + 14'h0001;
            end
        end
    end

    // ****************************************************************
    // Interrupt mask and low-power modes
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (!nrst) begin
            int_mask <= 1'b1;
        end else if (clock_en) begin
            if (take_irq || (accept && cmd == CMD_SEI)) begin
                int_mask <= 1'b1;
            end else if (accept && cmd == CMD_CLI) begin
                int_mask <= 1'b0;
            end
        end
    end

    // Wake ignores the mask; entry then follows only if unmasked
    always_ff @(posedge clock) begin
        if (!nrst) begin
            stopped <= 1'b0;
            wait_mode <= 1'b0;
        end else if (clock_en) begin
            if (stopped) begin
                stopped <= !stop_wake;
            end else if (accept && cmd == CMD_STOP) begin
                stopped <= 1'b1;
            end
            if (wait_mode) begin
                wait_mode <= !any_req;
            end else if (accept && cmd == CMD_WAIT) begin
                wait_mode <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Supply monitor pin interrupt
    // ****************************************************************
    assign pin_rise = !pin_prev && supply_monitor_pin;
    assign pin_fall = pin_prev && !supply_monitor_pin;

    // Reset is synchronous, so the pin level is caught at a clock edge
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pin_prev <= supply_monitor_pin;
            skip_rise <= power_on;
        end else if (clock_en) begin
            pin_prev <= supply_monitor_pin;
            if (pin_rise || pin_prev) begin
                skip_rise <= 1'b0;
            end
        end
    end

    // An edge in the ack cycle sets the flag again: set beats clear
    always_ff @(posedge clock) begin
        if (!nrst) begin
            supply_irq_flag <= 1'b0;
        end else if (clock_en) begin
            if (supply_irq_enable
                && (pin_fall || (pin_rise && !skip_rise))) begin
                supply_irq_flag <= 1'b1;
            end else if (supply_irq_ack) begin
                supply_irq_flag <= 1'b0;
            end
        end
    end

    // Options byte view; the ack position always reads as zero
    always_ff @(posedge clock) begin
        if (!nrst) begin
            supply_options <= 8'h00;
        end else if (clock_en) begin
            supply_options <= 8'h00;
            supply_options[OPT_FLAG_POS] <= supply_irq_flag;
            supply_options[OPT_LEVEL_POS] <= supply_monitor_pin;
            supply_options[OPT_ACK_POS] <= 1'b0;
            supply_options[OPT_ENABLE_POS] <= supply_irq_enable;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence seq_entry_start;
        take_irq && clock_en;
    endsequence

    sequence seq_five_pushes;
        clock_en [*5];
    endsequence

    a_sp_reset_top: assert property (@(posedge clock)
        $rose(nrst) |-> sp == STACK_TOP && int_mask)
        else $error("stack pointer or mask wrong after reset");

    a_stack_fixed_high: assert property (@(posedge clock) disable iff (!nrst)
        stack_pointer[15:6] == 10'h003)
        else $error("stack pointer high bits changed");

    a_push_decrement: assert property (@(posedge clock) disable iff (!nrst)
        accept && clock_en && cmd == CMD_PUSH
        |=> sp == $past(sp) - 6'h01)
        else $error("push did not decrement stack pointer");

    a_pull_increment: assert property (@(posedge clock) disable iff (!nrst)
        pull_go && clock_en |=> sp == $past(sp) + 6'h01)
        else $error("pull did not increment stack pointer");

    a_entry_five_bytes: assert property (@(posedge clock)
        disable iff (!nrst)
        seq_entry_start ##1 seq_five_pushes
        |=> sp == $past(sp, 6) - 6'h05)
        else $error("interrupt entry did not use five bytes");

    a_call_two_bytes: assert property (@(posedge clock) disable iff (!nrst)
        accept && clock_en && cmd == CMD_CALL ##1 clock_en [*2]
        |=> sp == $past(sp, 3) - 6'h02 && state == S_IDLE)
        else $error("call did not use two bytes");

    a_fetch_advance: assert property (@(posedge clock) disable iff (!nrst)
        accept && clock_en && cmd == CMD_FETCH
        |=> pc == $past(pc) + 14'h0001)
        else $error("fetch did not advance program counter");

    a_half_carry_add: assert property (@(posedge clock) disable iff (!nrst)
        accept && clock_en && cmd == CMD_ADD
        |=> half_carry == ($past(accumulator[3:0])
            + $past(cmd_data[3:0]) > 5'h0f))
        else $error("half carry wrong after add");

    a_supply_ack_clear: assert property (@(posedge clock)
        disable iff (!nrst)
        clock_en && supply_irq_ack && !pin_rise && !pin_fall
        |=> !supply_irq_flag)
        else $error("ack did not clear supply flag");

    a_supply_disabled: assert property (@(posedge clock)
        disable iff (!nrst)
        !supply_irq_enable && !supply_irq_flag |=> !supply_irq_flag)
        else $error("supply flag set while disabled");

    a_wait_wakeup: assert property (@(posedge clock) disable iff (!nrst)
        wait_mode && any_req && clock_en |=> !wait_mode)
        else $error("wait mode not left on request");

endmodule : crie_core

/* File: crie_vector_mem.sv */
// Memory model that answers the core's vector byte reads
`timescale 1ns/100ps
module crie_vector_mem
    import crie_pkg::*;
(
    input wire logic clock,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    output logic [7:0] mem_rdata
);
    // ****************************************************************
    // Read answer
    // ****************************************************************
    // Good only the cycle after the strobe, else it toggles, so a
    // mistimed capture cannot match
    always @(posedge clock) begin
        if (mem_rd === 1'b1) begin
            mem_rdata <= mem_addr[7:0] ^ 8'h3c;
        end else begin
            mem_rdata <= (mem_rdata === 8'h5a) ? 8'ha5 : 8'h5a;
        end
    end
endmodule : crie_vector_mem

/* File: testbench.sv */
// Self-checking bench for the core register and interrupt entry block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench
    import crie_pkg::*;
;
    // ****************************************************************
    // Signals, instances and tasks
    // ****************************************************************
    logic clock, clock_en, nrst, power_on, carry_in, cmd_ready, half_carry;
    logic carry_out, int_mask, mem_rd, keypad_irq_enable, ext_irq;
    logic core_timer_irq, supply_monitor_pin, supply_irq_enable;
    logic supply_irq_ack, supply_irq_flag, osc_run, wait_mode, busy;
    crie_cmd_type cmd;
    logic [7:0] cmd_data, accumulator, index_reg, pull_data, mem_rdata;
    logic [7:0] timer_status_reg, timer_control_reg, portc_in;
    logic [7:0] portc_direction, supply_options;
    logic [15:0] cmd_addr, stack_pointer, program_counter, mem_addr;
    logic [15:0] vecs [6] = '{EXT_VECTOR, TIMER_VECTOR, TIMER_VECTOR,
        TIMER_VECTOR, KEYPAD_VECTOR, CORE_TIMER_VECTOR};
    int num_errors = 0;
    int checks_done = 0;

    crie_core u_dut (.clock(clock), .clock_en(clock_en), .nrst(nrst),
        .power_on(power_on), .cmd(cmd), .cmd_data(cmd_data),
        .cmd_addr(cmd_addr), .carry_in(carry_in), .cmd_ready(cmd_ready),
        .accumulator(accumulator), .index_reg(index_reg),
        .stack_pointer(stack_pointer), .program_counter(program_counter),
        .half_carry(half_carry), .carry_out(carry_out), .int_mask(int_mask),
        .pull_data(pull_data), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata), .timer_status_reg(timer_status_reg),
        .timer_control_reg(timer_control_reg), .portc_in(portc_in),
        .portc_direction(portc_direction),
        .keypad_irq_enable(keypad_irq_enable), .ext_irq(ext_irq),
        .core_timer_irq(core_timer_irq),
        .supply_monitor_pin(supply_monitor_pin),
        .supply_irq_enable(supply_irq_enable),
        .supply_irq_ack(supply_irq_ack), .supply_irq_flag(supply_irq_flag),
        .supply_options(supply_options), .osc_run(osc_run),
        .wait_mode(wait_mode), .busy(busy));
    crie_vector_mem u_mem (.clock(clock), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata));

    // Expected pc after a vector load; top bits dropped
    function automatic logic [15:0] vec_pc(input logic [15:0] v);
        return {2'b00, v[5:0] ^ 6'h3c, (v[7:0] + 8'h01) ^ 8'h3c};
    endfunction : vec_pc

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    // Bounded wait so a stuck sequencer cannot hang the run
    task automatic idle();
        int n = 0;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
    endtask : idle

    // One command, offered for exactly one accepting edge
    task automatic run(input crie_cmd_type c, input logic [7:0] d = 8'h00,
                       input logic [15:0] a = 16'h0000);
        idle();
        @(posedge clock);
        cmd <= c;
        cmd_data <= d;
        cmd_addr <= a;
        @(posedge clock);
        cmd <= CMD_NONE;
        tick(3);
    endtask : run

    task automatic do_reset(input logic po);
        @(posedge clock);
        nrst <= 1'b0;
        power_on <= po;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        tick(2);
        idle();
        `CHK("sp_rst", 16'h00ff, stack_pointer)
        `CHK("mask_rst", 1'b1, int_mask)
        `CHK("flag_rst", 1'b0, supply_irq_flag)
        `CHK("pc_rst", vec_pc(RESET_VECTOR), program_counter)
    endtask : do_reset

    // Sources are levels; drive at the clock edge
    task automatic src(input int i, input logic on);
        case (i)
            0: ext_irq <= on;
            1, 2, 3: begin
                timer_status_reg <= on ? (8'h10 << i[1:0]) : 8'h00;
                timer_control_reg <= 8'h10 << i[1:0];
            end
            4: portc_in <= on ? 8'hfb : 8'hff;
            default: core_timer_irq <= on;
        endcase
    endtask : src

    task automatic pin(input logic v);
        @(posedge clock);
        supply_monitor_pin <= v;
        tick(3);
    endtask : pin

    task automatic ack();
        @(posedge clock);
        supply_irq_ack <= 1'b1;
        @(posedge clock);
        supply_irq_ack <= 1'b0;
        tick(2);
    endtask : ack

    task automatic entry(input logic [15:0] v);
        logic [15:0] sp0;
        sp0 = stack_pointer;
        run(CMD_CLI);
        idle();
        `CHK("irq_sp", {10'h003, sp0[5:0] - 6'd5}, stack_pointer)
        `CHK("irq_pc", vec_pc(v), program_counter)
    endtask : entry

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // ****************************************************************
    // Clock, watchdog and tests
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // The tests need some 600 cycles; the 20000-cycle limit means a hang
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end

    initial begin
        clock_en = 1'b1; nrst = 1'b0; power_on = 1'b1; carry_in = 1'b0;
        cmd = CMD_NONE; cmd_data = 8'h00; cmd_addr = 16'h0000;
        timer_status_reg = 8'h00; timer_control_reg = 8'h00;
        portc_in = 8'hff; portc_direction = 8'h00; keypad_irq_enable = 1'b1;
        ext_irq = 1'b0; core_timer_irq = 1'b0; supply_monitor_pin = 1'b0;
        supply_irq_enable = 1'b1; supply_irq_ack = 1'b0;
        do_reset(1'b1);
        pin(1'b1);
        `CHK("rise_po", 1'b0, supply_irq_flag)
        pin(1'b0);
        `CHK("fall", 1'b1, supply_irq_flag)
        `CHK("options", 8'h90, supply_options)
        ack();
        `CHK("ack", 1'b0, supply_irq_flag)
        @(posedge clock);
        supply_irq_enable <= 1'b0;
        pin(1'b1);
        `CHK("disabled", 1'b0, supply_irq_flag)
        @(posedge clock);
        supply_irq_enable <= 1'b1;
        pin(1'b0);
        entry(SUPPLY_VECTOR);
        ack();
        // Flags without enables and keys on output pins stay quiet
        @(posedge clock);
        timer_status_reg <= 8'he0;
        portc_direction <= 8'hff;
        portc_in <= 8'h00;
        run(CMD_CLI);
        `CHK("no_entry", 1'b0, busy)
        run(CMD_SEI);
        timer_status_reg <= 8'h00;
        portc_direction <= 8'h00;
        portc_in <= 8'hff;
        for (int i = 0; i < 6; i++) begin
            @(posedge clock);
            src(i, 1'b1);
            entry(vecs[i]);
            @(posedge clock);
            src(i, 1'b0);
        end
        run(CMD_LOAD_X, 8'h5c);
        run(CMD_LOAD_A, 8'h0f);
        run(CMD_ADD, 8'h01);
        `CHK("hc_set", 1'b1, half_carry)
        run(CMD_ADD, 8'hf0);
        `CHK("hc_clr", 1'b0, half_carry)
        `CHK("carry", 1'b1, carry_out)
        @(posedge clock);
        carry_in <= 1'b1;
        run(CMD_ADC, 8'h0f);
        `CHK("hc_adc", 1'b1, half_carry)
        do_reset(1'b0);
        `CHK("acc", 8'h10, accumulator)
        `CHK("index", 8'h5c, index_reg)
        run(CMD_PUSH, 8'ha5);
        `CHK("sp_push", 16'h00fe, stack_pointer)
        run(CMD_PULL);
        `CHK("pull", 8'ha5, pull_data)
        `CHK("sp_pull", 16'h00ff, stack_pointer)
        for (int i = 0; i < 64; i++) begin
            run(CMD_PUSH, 8'(i));
            if (i == 62) `CHK("sp_low", 16'h00c0, stack_pointer)
        end
        `CHK("sp_wrap", 16'h00ff, stack_pointer)
        run(CMD_PUSH, 8'h3c);
        run(CMD_RSP);
        `CHK("rsp", 16'h00ff, stack_pointer)
        run(CMD_JUMP, 8'h00, 16'hc123);
        `CHK("jump", 16'h0123, program_counter)
        run(CMD_FETCH, 8'h00, 16'hc123);
        `CHK("fetch", 16'h0124, program_counter)
        run(CMD_CALL, 8'h00, 16'h0456);
        `CHK("call_pc", 16'h0456, program_counter)
        `CHK("call_sp", 16'h00fd, stack_pointer)
        run(CMD_WAIT);
        `CHK("wait", 1'b1, wait_mode)
        @(posedge clock);
        src(5, 1'b1);
        tick(3);
        `CHK("wake", 1'b0, wait_mode)
        src(5, 1'b0);
        run(CMD_STOP);
        `CHK("stop", 1'b0, osc_run)
        @(posedge clock);
        src(0, 1'b1);
        tick(3);
        `CHK("restart", 1'b1, osc_run)
        give_verdict();
    end
endmodule : testbench
